// ---- logic/bk1_regs.sv ----
// Bank 1 special function register block with mirrored core registers.
// Assumes the core presents in-bank addresses and one-cycle strobes.
//
// Operation
// RULE_01 - Unimplemented bits read zero and ignore writes.
// RULE_02 - Unimplemented addresses read zero and ignore writes.
// RULE_03 - Mirrored registers map to one storage in every bank.
// RULE_04 - Program counter upper byte has no address of its own.
// RULE_05 - Five-bit high latch is copied to PC bits 12:8 on update.
// RULE_06 - Port A direction bit 5 is read-only, always reads one.
// RULE_07 - Indirect port access is redirected to the pointer address.
`timescale 1ns/1ns
module bk1_regs
  import bk1_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Indirect access to data memory
  output logic IND_WR,
  output logic IND_RD,
  output logic [7:0] IND_ADDR,
  output logic [7:0] IND_WDATA,
  input wire logic [7:0] IND_RDATA,
  // Program counter interface
  input wire logic PC_LOAD,
  input wire logic [7:0] PC_LOW_IN,
  output logic [4:0] PC_HIGH,
  output logic [7:0] PC_LOW,
  // Core and peripheral status
  input wire logic STATUS_SET,
  input wire logic [7:0] STATUS_IN,
  input wire logic [7:0] INT_FLAGS_IN,
  input wire logic OSC_STABLE,
  input wire logic [7:0] SER_STAT_IN,
  input wire logic [7:0] ADC_LOW_IN,
  // Configuration outputs
  output logic [7:0] OPTION_OUT,
  output logic [7:0] DIR_A_OUT,
  output logic [7:0] DIR_B_OUT,
  output logic [7:0] INT_CTL_OUT,
  output logic [7:0] PERIPHERAL_IRQ_ENABLE_1_OUT,
  output logic [7:0] PERIPHERAL_IRQ_ENABLE_2_OUT,
  output logic [7:0] OSC_CTL_OUT,
  output logic [7:0] OSC_TRIM_OUT,
  output logic [7:0] T2_PERIOD_OUT,
  output logic [7:0] SER_ADDR_OUT,
  output logic [7:0] ADC_CTL1_OUT
);
  // ****************
  // Decode
  // ****************
  // Mirrored registers ignore the bank bits of the address
  wire [7:0] low_addr = ADDR & BK1_BANK_MASK; // see RULE_03
  wire [7:0] bank_addr = {1'b1, ADDR[6:0]};
  wire is_bank1 = ADDR[7];
  wire hit_ind = low_addr == (BK1_IND_PORT & BK1_BANK_MASK); // see RULE_03
  wire hit_pcl = low_addr == (BK1_PC_LOW & BK1_BANK_MASK);
  wire hit_stat = low_addr == (BK1_STATUS & BK1_BANK_MASK);
  wire hit_ptr = low_addr == (BK1_IND_PTR & BK1_BANK_MASK);
  wire hit_latch = low_addr == (BK1_PC_LATCH & BK1_BANK_MASK);
  wire hit_intc = low_addr == (BK1_INT_CTL & BK1_BANK_MASK);
  wire hit_trim = low_addr == (BK1_OSC_TRIM & BK1_BANK_MASK);
  wire hit_opt = is_bank1 && bank_addr == BK1_OPTION;
  wire hit_dira = is_bank1 && bank_addr == BK1_DIR_A;
  wire hit_dirb = is_bank1 && bank_addr == BK1_DIR_B;
  wire hit_peripheral_irq_enable_1 = is_bank1 && bank_addr == BK1_PERIPHERAL_IRQ_ENABLE_1;
  wire hit_peripheral_irq_enable_2 = is_bank1 && bank_addr == BK1_PERIPHERAL_IRQ_ENABLE_2;
  wire hit_rst = is_bank1 && bank_addr == BK1_RST_CAUSE;
  wire hit_osc = is_bank1 && bank_addr == BK1_OSC_CTL;
  wire hit_t2 = is_bank1 && bank_addr == BK1_T2_PERIOD;
  wire hit_sera = is_bank1 && bank_addr == BK1_SER_ADDR;
  wire hit_sers = is_bank1 && bank_addr == BK1_SER_STAT;
  wire hit_adcl = is_bank1 && bank_addr == BK1_ADC_LOW;
  wire hit_adcc = is_bank1 && bank_addr == BK1_ADC_CTL1;
  // ****************
  // Write enables
  // ****************
  // One named strobe per register keeps the clocked blocks trivial
  wire wr_pcl = WR && hit_pcl;
  wire wr_stat = WR && hit_stat;
  wire wr_ptr = WR && hit_ptr;
  wire wr_latch = WR && hit_latch;
  wire wr_intc = WR && hit_intc;
  wire wr_trim = WR && hit_trim;
  wire wr_opt = WR && hit_opt;
  wire wr_dira = WR && hit_dira;
  wire wr_dirb = WR && hit_dirb;
  wire wr_peripheral_irq_enable_1 = WR && hit_peripheral_irq_enable_1;
  wire wr_peripheral_irq_enable_2 = WR && hit_peripheral_irq_enable_2;
  wire wr_rst = WR && hit_rst;
  wire wr_osc = WR && hit_osc;
  wire wr_t2 = WR && hit_t2;
  wire wr_sera = WR && hit_sera;
  wire wr_adcc = WR && hit_adcc;
  // ****************
  // Storage
  // ****************
  logic [7:0] opt_r, pcl_r, stat_r, ptr_r, dirb_r, latch_r, intc_r;
  logic [7:0] peripheral_irq_enable_1_r, peripheral_irq_enable_2_r, rst_r, osc_r, trim_r, t2_r, sera_r, adcc_r;
  logic [7:0] rdata_r;
  logic [7:0] dira_v;
  // Hardware flag set beats a software write in the same cycle
  wire [7:0] int_flags = INT_FLAGS_IN & BK1_M_INT_FLAGS;
  wire [7:0] next_stat = STATUS_SET ? STATUS_IN :
    wr_stat ? ((WDATA & BK1_M_STATUS_WR) | (stat_r & ~BK1_M_STATUS_WR)) : stat_r;
  wire [7:0] next_intc = (wr_intc ? WDATA : intc_r) | int_flags;
  wire [7:0] next_pcl = PC_LOAD ? PC_LOW_IN : WDATA;
  // Only the low five bits exist in the latch
  wire [7:0] next_latch = WDATA & BK1_M_PC_LATCH; // see RULE_01
  wire [7:0] next_trim = WDATA & BK1_M_OSC_TRIM; // see RULE_01
  wire [7:0] next_peripheral_irq_enable_1 = WDATA & BK1_M_PERIPHERAL_IRQ_ENABLE_1; // see RULE_01
  wire [7:0] next_peripheral_irq_enable_2 = WDATA & BK1_M_PERIPHERAL_IRQ_ENABLE_2; // see RULE_01
  wire [7:0] next_rst = WDATA & BK1_M_RST_CAUSE; // see RULE_01
  // Stable flag bit is hardware-owned, not stored
  wire [7:0] next_osc = WDATA & BK1_M_OSC_WR; // see RULE_01
  wire [7:0] next_adcc = WDATA & BK1_M_ADC_CTL1; // see RULE_01
  // ****************
  // Register flip-flops
  // ****************
  // Status keeps its power-down flags on a software write
  always_ff @(posedge CLK) begin
    if (SRST) begin
      stat_r <= BK1_RST_STATUS;
    end else begin
      stat_r <= next_stat;
    end
  end
  // Sticky flags: a set in the write cycle survives the write
  always_ff @(posedge CLK) begin
    if (SRST) begin
      intc_r <= BK1_RST_ZERO;
    end else begin
      intc_r <= next_intc;
    end
  end
  // Core load wins over a software write
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pcl_r <= BK1_RST_ZERO;
    end else if (PC_LOAD || wr_pcl) begin
      pcl_r <= next_pcl;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ptr_r <= BK1_RST_ZERO;
    end else if (wr_ptr) begin
      ptr_r <= WDATA;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      latch_r <= BK1_RST_ZERO;
    end else if (wr_latch) begin
      latch_r <= next_latch;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      trim_r <= BK1_RST_ZERO;
    end else if (wr_trim) begin
      trim_r <= next_trim;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      opt_r <= BK1_RST_ONES;
    end else if (wr_opt) begin
      opt_r <= WDATA;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      dirb_r <= BK1_RST_ONES;
    end else if (wr_dirb) begin
      dirb_r <= WDATA;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      peripheral_irq_enable_1_r <= BK1_RST_ZERO;
    end else if (wr_peripheral_irq_enable_1) begin
      peripheral_irq_enable_1_r <= next_peripheral_irq_enable_1;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      peripheral_irq_enable_2_r <= BK1_RST_ZERO;
    end else if (wr_peripheral_irq_enable_2) begin
      peripheral_irq_enable_2_r <= next_peripheral_irq_enable_2;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rst_r <= BK1_RST_CAUSE_V;
    end else if (wr_rst) begin
      rst_r <= next_rst;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      osc_r <= BK1_RST_ZERO;
    end else if (wr_osc) begin
      osc_r <= next_osc;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      t2_r <= BK1_RST_ONES;
    end else if (wr_t2) begin
      t2_r <= WDATA;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sera_r <= BK1_RST_ZERO;
    end else if (wr_sera) begin
      sera_r <= WDATA;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      adcc_r <= BK1_RST_ZERO;
    end else if (wr_adcc) begin
      adcc_r <= next_adcc;
    end
  end
  bk1_dir_a u_dir_a (
    .clk(CLK),
    .srst(SRST),
    .wr(wr_dira),
    .wdata(WDATA),
    .value(dira_v)
  );
  // ****************
  // Indirect path
  // ****************
  // Redirected to data memory; the port itself holds nothing
  assign IND_WR = WR && hit_ind; // see RULE_07
  assign IND_RD = RD && hit_ind; // see RULE_07
  assign IND_ADDR = ptr_r;
  assign IND_WDATA = WDATA;
  // ****************
  // Read mux
  // ****************
  // Stable flag joins the stored bits only on the read path
  wire [7:0] osc_rd = osc_r | (OSC_STABLE ? (8'h01 << BK1_OSC_STABLE_BIT) : 8'h00);
  // Hit terms are mutually exclusive, so the order is harmless
  wire [7:0] rd_sel =
    hit_pcl ? pcl_r :
    hit_stat ? stat_r :
    hit_ptr ? ptr_r :
    hit_latch ? latch_r :
    hit_intc ? intc_r :
    hit_trim ? trim_r :
    hit_opt ? opt_r :
    hit_dira ? dira_v :
    hit_dirb ? dirb_r :
    hit_peripheral_irq_enable_1 ? peripheral_irq_enable_1_r :
    hit_peripheral_irq_enable_2 ? peripheral_irq_enable_2_r :
    hit_rst ? rst_r :
    hit_osc ? (osc_rd & BK1_M_OSC_CTL) :
    hit_t2 ? t2_r :
    hit_sera ? sera_r :
    hit_sers ? SER_STAT_IN :
    hit_adcl ? ADC_LOW_IN :
    hit_adcc ? adcc_r :
    BK1_RST_ZERO; // see RULE_02
  // Memory data is captured with the strobe so the bus sees a flop
  wire [7:0] next_rdata = !RD ? BK1_RST_ZERO : hit_ind ? IND_RDATA : rd_sel; // see RULE_07
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdata_r <= BK1_RST_ZERO;
    end else begin
      rdata_r <= next_rdata;
    end
  end
  assign RDATA = rdata_r;
  // ****************
  // Program counter and outputs
  // ****************
  // Upper byte reaches the core only through the latch
  assign PC_HIGH = latch_r[4:0]; // see RULE_04, see RULE_05
  assign PC_LOW = pcl_r;
  assign OPTION_OUT = opt_r;
  assign DIR_A_OUT = dira_v;
  assign DIR_B_OUT = dirb_r;
  assign INT_CTL_OUT = intc_r;
  assign PERIPHERAL_IRQ_ENABLE_1_OUT = peripheral_irq_enable_1_r;
  assign PERIPHERAL_IRQ_ENABLE_2_OUT = peripheral_irq_enable_2_r;
  assign OSC_CTL_OUT = osc_r;
  assign OSC_TRIM_OUT = trim_r;
  assign T2_PERIOD_OUT = t2_r;
  assign SER_ADDR_OUT = sera_r;
  assign ADC_CTL1_OUT = adcc_r;
endmodule

// ---- inc/bk1_pkg.sv ----
// Package for the bank 1 special register block: offsets, masks, reset values.
// Assumes an 8-bit data path and a 7-bit in-bank address from the core.
package bk1_pkg;
  // ****************
  // Offsets
  // ****************
  localparam logic [7:0] BK1_IND_PORT = 8'h80;
  localparam logic [7:0] BK1_OPTION = 8'h81;
  localparam logic [7:0] BK1_PC_LOW = 8'h82;
  localparam logic [7:0] BK1_STATUS = 8'h83;
  localparam logic [7:0] BK1_IND_PTR = 8'h84;
  localparam logic [7:0] BK1_DIR_A = 8'h85;
  localparam logic [7:0] BK1_DIR_B = 8'h86;
  localparam logic [7:0] BK1_PC_LATCH = 8'h8a;
  localparam logic [7:0] BK1_INT_CTL = 8'h8b;
  localparam logic [7:0] BK1_PERIPHERAL_IRQ_ENABLE_1 = 8'h8c;
  localparam logic [7:0] BK1_PERIPHERAL_IRQ_ENABLE_2 = 8'h8d;
  localparam logic [7:0] BK1_RST_CAUSE = 8'h8e;
  localparam logic [7:0] BK1_OSC_CTL = 8'h8f;
  localparam logic [7:0] BK1_OSC_TRIM = 8'h90;
  localparam logic [7:0] BK1_T2_PERIOD = 8'h92;
  localparam logic [7:0] BK1_SER_ADDR = 8'h93;
  localparam logic [7:0] BK1_SER_STAT = 8'h94;
  localparam logic [7:0] BK1_ADC_LOW = 8'h9e;
  localparam logic [7:0] BK1_ADC_CTL1 = 8'h9f;
  localparam logic [7:0] BK1_BANK_MASK = 8'h7f;
  // ****************
  // Implemented bit masks
  // ****************
  localparam logic [7:0] BK1_M_PC_LATCH = 8'h1f;
  localparam logic [7:0] BK1_M_PERIPHERAL_IRQ_ENABLE_1 = 8'h4f;
  localparam logic [7:0] BK1_M_PERIPHERAL_IRQ_ENABLE_2 = 8'h10;
  localparam logic [7:0] BK1_M_RST_CAUSE = 8'h03;
  localparam logic [7:0] BK1_M_OSC_CTL = 8'h74;
  localparam logic [7:0] BK1_M_OSC_WR = 8'h70;
  localparam logic [7:0] BK1_M_OSC_TRIM = 8'h3f;
  localparam logic [7:0] BK1_M_ADC_CTL1 = 8'hcf;
  localparam logic [7:0] BK1_M_STATUS_WR = 8'he7;
  localparam logic [7:0] BK1_M_SER_WR = 8'hc0;
  localparam logic [7:0] BK1_M_INT_FLAGS = 8'h07;
  localparam logic [7:0] BK1_DIR_A_FIXED = 8'h20;
  localparam int BK1_OSC_STABLE_BIT = 2;
  // ****************
  // Reset values
  // ****************
  localparam logic [7:0] BK1_RST_ONES = 8'hff;
  localparam logic [7:0] BK1_RST_ZERO = 8'h00;
  localparam logic [7:0] BK1_RST_STATUS = 8'h18;
  localparam logic [7:0] BK1_RST_CAUSE_V = 8'h03;
  localparam int BK1_N_RESET_ONES = 4;
endpackage

// ---- logic/bk1_dir_a.sv ----
// Port A direction register with a fixed input-only bit.
// Assumes write strobe and data synchronous to CLK.
`timescale 1ns/1ns
module bk1_dir_a
  import bk1_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Write side
  input wire logic wr,
  input wire logic [7:0] wdata,
  // Stored value
  output logic [7:0] value
);
  logic [7:0] store;
  always_ff @(posedge clk) begin
    if (srst) begin
      store <= BK1_RST_ONES;
    end else if (wr) begin
      store <= wdata;
    end
  end
  // Bit 5 is forced high whatever was written
  assign value = store | BK1_DIR_A_FIXED; // see RULE_06
endmodule

// ---- bench/bk1_regs_asserts.sv ----
// Concurrent checks for the bank 1 register block.
// Assumes it is bound to bk1_regs and sees only that module's ports.
`timescale 1ns/1ns
module bk1_regs_asserts
  import bk1_pkg::*;
(
  // Clock, reset and register port
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // Indirect, program counter and config
  input wire logic IND_WR,
  input wire logic IND_RD,
  input wire logic [7:0] IND_WDATA,
  input wire logic [7:0] IND_ADDR,
  input wire logic [7:0] IND_RDATA,
  input wire logic [4:0] PC_HIGH,
  input wire logic [7:0] DIR_A_OUT,
  input wire logic [7:0] PERIPHERAL_IRQ_ENABLE_2_OUT
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SRST);
  // ****************
  // Properties
  // ****************
  AST_UNMAP_ZERO: assert property (
    RD && ADDR inside {8'h87, 8'h91, 8'h9d} |=> RDATA == 8'h00) else $error("unmapped read");
  AST_LATCH_BITS: assert property (
    RD && ADDR == BK1_PC_LATCH |=> RDATA[7:5] == 3'h0) else $error("latch top bits");
  AST_PERIPHERAL_IRQ_ENABLE_2_BITS: assert property (
    (PERIPHERAL_IRQ_ENABLE_2_OUT & ~BK1_M_PERIPHERAL_IRQ_ENABLE_2) == 8'h00) else $error("peripheral_irq_enable_2 spare bits");
  AST_DIRA_BIT5: assert property (
    DIR_A_OUT[5] == 1'b1) else $error("dir a bit5 low");
  AST_DIRA_WR: assert property (
    WR && ADDR == BK1_DIR_A |=> DIR_A_OUT == ($past(WDATA) | BK1_DIR_A_FIXED))
    else $error("dir a write");
  AST_LATCH_COPY: assert property (
    WR && ADDR[6:0] == 7'h0a |=> PC_HIGH == $past(WDATA[4:0])) else $error("pc high copy");
  AST_PC_HIGH_HOLD: assert property (
    !(WR && ADDR[6:0] == 7'h0a) |=> $stable(PC_HIGH)) else $error("pc high moved");
  AST_IND_STROBE: assert property (
    IND_WR == (WR && ADDR[6:0] == 7'h00)) else $error("indirect write strobe");
  AST_IND_DATA: assert property (
    RD && ADDR[6:0] == 7'h00 |=> RDATA == $past(IND_RDATA)) else $error("indirect read data");
  AST_IND_RD_STROBE: assert property (
    IND_RD == (RD && ADDR[6:0] == 7'h00)) else $error("indirect read strobe");
  AST_IND_WDATA: assert property (
    IND_WR |-> IND_WDATA == WDATA) else $error("indirect write data");
  AST_PTR_ADDR: assert property (
    WR && ADDR[6:0] == 7'h04 |=> IND_ADDR == $past(WDATA)) else $error("pointer address");
endmodule
bind bk1_regs bk1_regs_asserts chk_u (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .IND_WR(IND_WR), .IND_RD(IND_RD),
  .IND_WDATA(IND_WDATA), .IND_ADDR(IND_ADDR),
  .IND_RDATA(IND_RDATA), .PC_HIGH(PC_HIGH), .DIR_A_OUT(DIR_A_OUT), .PERIPHERAL_IRQ_ENABLE_2_OUT(PERIPHERAL_IRQ_ENABLE_2_OUT));

// ---- bench/bk1_regs_tb.sv ----
// Self-checking bench for the bank 1 register block.
// Assumes bk1_pkg is compiled first; the bench acts as the core.
`timescale 1ns/1ns
module bk1_regs_tb;
  import bk1_pkg::*;
  logic CLK, SRST, WR, RD, OSC_STABLE;
  logic [7:0] ADDR, WDATA, RDATA, IND_RDATA, SER_STAT_IN, ADC_LOW_IN, a, d;
  logic [7:0] OPTION_OUT, DIR_A_OUT, DIR_B_OUT, INT_CTL_OUT, PERIPHERAL_IRQ_ENABLE_1_OUT, PERIPHERAL_IRQ_ENABLE_2_OUT, OSC_CTL_OUT;
  logic [7:0] OSC_TRIM_OUT, T2_PERIOD_OUT, SER_ADDR_OUT, ADC_CTL1_OUT, PC_LOW, IND_ADDR;
  logic [4:0] PC_HIGH;
  logic [7:0] mdl [0:31];
  int failures, total_checks;
  bk1_regs dut_u (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IND_WR(), .IND_RD(), .IND_ADDR(IND_ADDR), .IND_WDATA(),
    .IND_RDATA(IND_RDATA), .PC_LOAD(1'b0), .PC_LOW_IN(8'h00), .PC_HIGH(PC_HIGH),
    .PC_LOW(PC_LOW), .STATUS_SET(1'b0), .STATUS_IN(8'h00), .INT_FLAGS_IN(8'h00),
    .OSC_STABLE(OSC_STABLE), .SER_STAT_IN(SER_STAT_IN), .ADC_LOW_IN(ADC_LOW_IN),
    .OPTION_OUT(OPTION_OUT), .DIR_A_OUT(DIR_A_OUT), .DIR_B_OUT(DIR_B_OUT),
    .INT_CTL_OUT(INT_CTL_OUT), .PERIPHERAL_IRQ_ENABLE_1_OUT(PERIPHERAL_IRQ_ENABLE_1_OUT), .PERIPHERAL_IRQ_ENABLE_2_OUT(PERIPHERAL_IRQ_ENABLE_2_OUT),
    .OSC_CTL_OUT(OSC_CTL_OUT), .OSC_TRIM_OUT(OSC_TRIM_OUT), .T2_PERIOD_OUT(T2_PERIOD_OUT),
    .SER_ADDR_OUT(SER_ADDR_OUT), .ADC_CTL1_OUT(ADC_CTL1_OUT));
  // ****************
  // Reference model
  // ****************
  function automatic logic [7:0] wmask(input logic [4:0] i);
    case (i)
      5'h01, 5'h02, 5'h04, 5'h06, 5'h0b, 5'h12, 5'h13: return 8'hff;
      5'h03: return BK1_M_STATUS_WR;
      5'h05: return 8'hdf;
      5'h0a: return BK1_M_PC_LATCH;
      5'h0c: return BK1_M_PERIPHERAL_IRQ_ENABLE_1;
      5'h0d: return BK1_M_PERIPHERAL_IRQ_ENABLE_2;
      5'h0e: return BK1_M_RST_CAUSE;
      5'h0f: return BK1_M_OSC_WR;
      5'h10: return BK1_M_OSC_TRIM;
      5'h1f: return BK1_M_ADC_CTL1;
      default: return 8'h00;
    endcase
  endfunction
  // Bank bit clear only reaches the mirrored set
  function automatic logic hit(input logic [7:0] x);
    return x[6:5] == 2'h0 &&
      (x[7] || x[4:0] inside {5'h00, 5'h02, 5'h03, 5'h04, 5'h0a, 5'h0b, 5'h10});
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] x);
    if (!hit(x)) return 8'h00;
    case (x[4:0])
      5'h00: return IND_RDATA;
      5'h14: return SER_STAT_IN;
      5'h1e: return ADC_LOW_IN;
      5'h0f: return mdl[15] | {5'h00, OSC_STABLE, 2'h0};
      default: return mdl[x[4:0]];
    endcase
  endfunction
  // ****************
  // Bus tasks
  // ****************
  task automatic wr(input logic [7:0] x, input logic [7:0] v);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= x;
    WDATA <= v;
    @(posedge CLK);
    WR <= 1'b0;
    if (hit(x)) mdl[x[4:0]] = (mdl[x[4:0]] & ~wmask(x[4:0])) | (v & wmask(x[4:0]));
  endtask
  task automatic rd(input logic [7:0] x);
    logic [7:0] e;
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= x;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    e = exp_rd(x);
    total_checks++;
    if (RDATA !== e) begin
      failures++;
      $display("[ERR] %0t read %h got %h want %h", $time, x, RDATA, e);
    end
  endtask
  // Every register output against the model; they stand until the next write
  task automatic chk_outs;
    logic [108:0] got, want;
    got = {OPTION_OUT, DIR_A_OUT, DIR_B_OUT, PC_LOW, IND_ADDR, INT_CTL_OUT, PERIPHERAL_IRQ_ENABLE_1_OUT,
      PERIPHERAL_IRQ_ENABLE_2_OUT, OSC_CTL_OUT, OSC_TRIM_OUT, T2_PERIOD_OUT, SER_ADDR_OUT, ADC_CTL1_OUT, PC_HIGH};
    want = {mdl[1], mdl[5], mdl[6], mdl[2], mdl[4], mdl[11], mdl[12], mdl[13], mdl[15],
      mdl[16], mdl[18], mdl[19], mdl[31], mdl[10][4:0]};
    total_checks++;
    if (got !== want) begin
      failures++;
      $display("[ERR] %0t outputs got %h want %h", $time, got, want);
    end
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****************
  // Stimulus
  // ****************
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    {SRST, WR, RD, OSC_STABLE, ADDR, WDATA} = {1'b1, 19'h0};
    {IND_RDATA, SER_STAT_IN, ADC_LOW_IN} = 24'h5a3cc3;
    for (int i = 0; i < 32; i++) mdl[i] = 8'h00;
    {mdl[1], mdl[5], mdl[6], mdl[18], mdl[3], mdl[14]} = 48'hffffffff1803;
    void'($urandom(82));
    repeat (5) @(posedge CLK);
    SRST <= 1'b0;
    for (int i = 0; i < 32; i++) rd(8'h80 | 8'(i));
    wr(8'h85, 8'h00);
    rd(8'h85);
    chk_outs();
    for (int n = 0; n < 600; n++) begin
      @(posedge CLK);
      a = 8'($urandom);
      if ($urandom % 4 != 0) a[6:5] = 2'h0;
      d = 8'($urandom);
      IND_RDATA <= 8'($urandom);
      SER_STAT_IN <= 8'($urandom);
      ADC_LOW_IN <= 8'($urandom);
      OSC_STABLE <= 1'($urandom);
      wr(a, d);
      rd(a);
      rd(a ^ 8'h80);
      chk_outs();
    end
    summarize();
  end
endmodule
